// *** ffs_defs.vh ***
// constants for the fuse failure supervisor decision logic
`ifndef FFS_DEFS_VH
`define FFS_DEFS_VH

`define FFS_CLK_HZ           100000000
`define FFS_TICK_MS          1
`define FFS_TICK_CYCLES      ((`FFS_CLK_HZ / 1000) * `FFS_TICK_MS)
`define FFS_SHORT_QUAL_S     5
`define FFS_LONG_QUAL_S      60
`define FFS_SHORT_QUAL_TICKS (`FFS_SHORT_QUAL_S * 1000 / `FFS_TICK_MS)
`define FFS_LONG_QUAL_TICKS  (`FFS_LONG_QUAL_S * 1000 / `FFS_TICK_MS)
`define FFS_CNT_W            17
`define FFS_TICK_W           17

`endif

// *** ffs_qual_timer.v ***
// qualification timer: condition held longer than a tick count
module ffs_qual_timer #(
    parameter CNT_W  = 17,
    parameter LIMIT  = 5000
) (
    input  wire clk_in,
    input  wire rst_n,
    input  wire tick,
    input  wire cond,
    output reg  held_q
);
    reg [CNT_W-1:0] cnt_q;
    localparam [31:0]      LIM32 = LIMIT;
    localparam [CNT_W-1:0] LIM   = LIM32[CNT_W-1:0];

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= {CNT_W{1'b0}};
            held_q <= 1'b0;
        end else if (!cond) begin
            cnt_q  <= {CNT_W{1'b0}};
            held_q <= 1'b0;
        end else if (tick && cnt_q != LIM) begin
            cnt_q  <= cnt_q + 1'b1;
            held_q <= 1'b0;
        end else if (cnt_q == LIM && tick) begin
            held_q <= 1'b1; // strictly longer than the limit
        end
    end
endmodule // ffs_qual_timer

// *** ffs_fuse_fail_supervisor.v ***
// decision logic of the voltage-circuit fuse failure supervisor
`include "ffs_defs.vh"

// Functional notes
// - negative-sequence detection asserts voltage block
// - neg-seq over 5 s, all low, hold: 3ph
// - healthy 60 s, neg-seq voltage 5 s, dead, closed
// - delta without all-low gives only general block
// - delta over 5 s, all low, hold: 3ph
// - vt small breaker open asserts voltage block
// - line disconnector open asserts voltage block
// - block input forces both outputs inactive
// - contact inputs read false when unconnected
// - two outputs: three-phase and general, general also set by three-phase
// - neg-seq flag: voltage high, current low
// - phase flagged low below seal-in level
// - delta detection held until voltages recover
module ffs_fuse_fail_supervisor #(
    parameter TICK_CYCLES = `FFS_TICK_CYCLES,
    parameter SHORT_TICKS = `FFS_SHORT_QUAL_TICKS,
    parameter LONG_TICKS  = `FFS_LONG_QUAL_TICKS
) (
    input  wire       clk_in,
    input  wire       rst_n_in,
    input  wire       neg_seq_volt_high_in,
    input  wire       neg_seq_curr_low_in,
    input  wire [2:0] phase_below_seal_in,
    input  wire [2:0] phase_below_delta_min_in,
    input  wire [2:0] delta_detect_in,
    input  wire [2:0] phase_curr_dead_in,
    input  wire       seal_in_enable_in,
    input  wire       block_in,
    input  wire       breaker_closed_in,
    input  wire       line_disconnector_open_in,
    input  wire       vt_small_breaker_open_in,
    output reg        voltage_block_out,
    output reg        three_phase_fail_out
);
    reg rst_m_q;
    reg rst_s_q;
    // reset release: async assert, sync deassert
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // contact inputs come from pins: two-stage synchronisers
    reg [3:0] pin_m_q;
    reg [3:0] pin_s_q;
    always @(posedge clk_in or negedge rst_s_q) begin
        if (!rst_s_q) begin
            pin_m_q <= 4'h0;
            pin_s_q <= 4'h0;
        end else begin
            pin_m_q <= {block_in, breaker_closed_in,
                        line_disconnector_open_in,
                        vt_small_breaker_open_in};
            pin_s_q <= pin_m_q;
        end
    end
    wire blk_s  = pin_s_q[3];
    wire cb_s   = pin_s_q[2];
    wire disc_s = pin_s_q[1];
    wire mcb_s  = pin_s_q[0];

    // periodic tick divider
    reg [`FFS_TICK_W-1:0] div_q;
    reg                   tick_q;
    localparam [31:0]            DIV_LAST32 = TICK_CYCLES - 1;
    localparam [`FFS_TICK_W-1:0] DIV_LAST   = DIV_LAST32[`FFS_TICK_W-1:0];
    always @(posedge clk_in or negedge rst_s_q) begin
        if (!rst_s_q) begin
            div_q  <= {`FFS_TICK_W{1'b0}};
            tick_q <= 1'b0;
        end else if (div_q == DIV_LAST) begin
            div_q  <= {`FFS_TICK_W{1'b0}};
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    wire neg_seq_ff = neg_seq_volt_high_in & neg_seq_curr_low_in;
    wire all_low    = &phase_below_seal_in;
    wire all_high   = ~|phase_below_seal_in;
    wire all_dead   = &phase_curr_dead_in;

    // delta detection latch per phase; new detection refused while low
    reg  [2:0] delta_q;
    reg  [2:0] delta_armed_q;
    always @(posedge clk_in or negedge rst_s_q) begin
        if (!rst_s_q) begin
            delta_q       <= 3'h0;
            delta_armed_q <= 3'h7;
        end else begin
            delta_q <= (delta_q | (delta_detect_in & delta_armed_q))
                       & phase_below_delta_min_in;
            delta_armed_q <= ~phase_below_delta_min_in;
        end
    end
    wire delta_ff = |delta_q;

    wire ns_5s;
    wire dl_5s;
    wire nv_5s;
    wire hi_60s;
    wire out_5s;

    ffs_qual_timer #(.CNT_W(`FFS_CNT_W), .LIMIT(SHORT_TICKS)) u_ns (
        .clk_in (clk_in),
        .rst_n  (rst_s_q),
        .tick   (tick_q),
        .cond   (neg_seq_ff),
        .held_q (ns_5s)
    );
    ffs_qual_timer #(.CNT_W(`FFS_CNT_W), .LIMIT(SHORT_TICKS)) u_dl (
        .clk_in (clk_in),
        .rst_n  (rst_s_q),
        .tick   (tick_q),
        .cond   (delta_ff),
        .held_q (dl_5s)
    );
    ffs_qual_timer #(.CNT_W(`FFS_CNT_W), .LIMIT(SHORT_TICKS)) u_nv (
        .clk_in (clk_in),
        .rst_n  (rst_s_q),
        .tick   (tick_q),
        .cond   (neg_seq_volt_high_in),
        .held_q (nv_5s)
    );
    ffs_qual_timer #(.CNT_W(`FFS_CNT_W), .LIMIT(LONG_TICKS)) u_hi (
        .clk_in (clk_in),
        .rst_n  (rst_s_q),
        .tick   (tick_q),
        .cond   (all_high),
        .held_q (hi_60s)
    );
    // output active 5 s qualifies seal-in hold
    ffs_qual_timer #(.CNT_W(`FFS_CNT_W), .LIMIT(SHORT_TICKS)) u_out (
        .clk_in (clk_in),
        .rst_n  (rst_s_q),
        .tick   (tick_q),
        .cond   (voltage_block_out | three_phase_fail_out),
        .held_q (out_5s)
    );

    wire ns_3ph = ns_5s & all_low & seal_in_enable_in;
    wire dl_3ph = dl_5s & all_low & seal_in_enable_in;
    wire open_ph = hi_60s & nv_5s & all_dead & cb_s;

    // seal-in: after 5 s active, hold until voltages normal again
    reg  seal_q;
    wire normal_v = all_high & ~neg_seq_volt_high_in;
    always @(posedge clk_in or negedge rst_s_q) begin
        if (!rst_s_q) begin
            seal_q <= 1'b0;
        end else if (blk_s || normal_v || !seal_in_enable_in) begin
            seal_q <= 1'b0;
        end else if (out_5s) begin
            seal_q <= 1'b1;
        end
    end

    reg three_d;
    reg gen_d;
    always @* begin
        three_d = ns_3ph | dl_3ph | (seal_q & three_phase_fail_out);
        gen_d   = neg_seq_ff
                | delta_ff
                | open_ph
                | mcb_s
                | disc_s
                | three_d
                | seal_q;
        if (blk_s) begin
            three_d = 1'b0;
            gen_d   = 1'b0;
        end
    end

    // registered outputs; voltage block also set by three_d
    always @(posedge clk_in or negedge rst_s_q) begin
        if (!rst_s_q) begin
            voltage_block_out    <= 1'b0;
            three_phase_fail_out <= 1'b0;
        end else begin
            voltage_block_out    <= gen_d;
            three_phase_fail_out <= three_d;
        end
    end
endmodule // ffs_fuse_fail_supervisor

// *** ffs_far_model.sv ***
// far-side model: comparator flags and contact inputs
module ffs_far_model (
    input  wire         clk_in,
    input  wire  [18:0] st_in,
    output logic [18:0] pins_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pins_out = 19'h0; // unwired contacts read false
    always @(posedge clk_in) pins_out <= #1 st_in;
endmodule // ffs_far_model

// *** ffs_fuse_fail_supervisor_assertions.sv ***
// port assertions for the supervisor decision logic
module ffs_chk #(parameter TICK_CYCLES = 4, parameter SHORT_TICKS = 5) (
    input wire       clk_in, rst_n_in, neg_seq_volt_high_in,
    input wire       neg_seq_curr_low_in, seal_in_enable_in, block_in,
    input wire [2:0] phase_below_seal_in, phase_below_delta_min_in,
    input wire [2:0] delta_detect_in, phase_curr_dead_in,
    input wire       breaker_closed_in, line_disconnector_open_in,
    input wire       vt_small_breaker_open_in,
    input wire       voltage_block_out, three_phase_fail_out
);
    logic [2:0] up_q;
    logic [6:0] det_q;
    wire rdy = &up_q;
    wire ok = rdy && !block_in;
    wire ns = neg_seq_volt_high_in && neg_seq_curr_low_in;
    wire dm = |phase_below_delta_min_in;
    wire dd = |delta_detect_in;
    // a hit only latches on a phase that is below the delta minimum
    wire dh = |(delta_detect_in & phase_below_delta_min_in);
    wire vb = voltage_block_out;
    wire tp = three_phase_fail_out;
    wire vt = vt_small_breaker_open_in;
    wire dc = line_disconnector_open_in;
    wire ea = seal_in_enable_in && &phase_below_seal_in;
    // generous: any cause of a held detection keeps the count going
    wire det = ns || dd || dm;
    wire quiet = !neg_seq_volt_high_in && !phase_below_seal_in && !dm &&
                 !dd && !vt && !dc;
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up_q <= 3'h0;
            det_q <= 7'h0;
        end else begin
            up_q <= up_q + {2'h0, ~&up_q};
            det_q <= det ? det_q + {6'h0, ~&det_q} : 7'h0;
        end
    end
    default clocking dc_cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_NEG_SEQ: assert property (ok [*4] ##0 ns |=> vb)
        else $error("neg seq did not block");
    AST_VT_OPEN: assert property ((ok && vt) [*5] |=> vb)
        else $error("vt breaker open did not block");
    AST_DISC_OPEN: assert property ((ok && dc) [*5] |=> vb)
        else $error("disconnector open did not block");
    AST_BLOCK: assert property (block_in [*5] |=> !vb && !tp)
        else $error("block input did not clear outputs");
    AST_DELTA: assert property (ok [*3] ##1 (ok && !dm) ##1 (ok && dh)
        ##1 ok |=> vb) else $error("delta detect did not block");
    AST_3PH_TIME: assert property ($rose(tp) |->
        det_q >= SHORT_TICKS * TICK_CYCLES) else $error("3ph too early");
    AST_3PH_EN: assert property ($rose(tp) |->
        $past(ea) || $past(ea, 2)) else $error("3ph without low/enable");
    AST_QUIET: assert property ((rdy && quiet) [*5] |=> !vb && !tp)
        else $error("output active without cause");
    cover property ($rose(tp));
    cover property ($rose(vb));
    cover property (block_in && vb);
endmodule // ffs_chk

bind ffs_fuse_fail_supervisor ffs_chk #(.TICK_CYCLES(TICK_CYCLES),
    .SHORT_TICKS(SHORT_TICKS)) chk_u (.*);

// *** ffs_fuse_fail_supervisor_tb.sv ***
// self-checking testbench for the supervisor decision logic
module ffs_fuse_fail_supervisor_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [18:0] st = 19'h0;
    wire  [18:0] p;
    wire         vb, tp;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    always #5 clk_in = ~clk_in;
    ffs_far_model far_u (.clk_in(clk_in), .st_in(st), .pins_out(p));
    // short tick and limits keep the run brief
    ffs_fuse_fail_supervisor #(.TICK_CYCLES(4), .SHORT_TICKS(5),
        .LONG_TICKS(20)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .neg_seq_volt_high_in(p[18]), .neg_seq_curr_low_in(p[17]),
        .phase_below_seal_in(p[16:14]), .phase_below_delta_min_in(p[13:11]),
        .delta_detect_in(p[10:8]), .phase_curr_dead_in(p[7:5]),
        .seal_in_enable_in(p[4]), .block_in(p[3]), .breaker_closed_in(p[2]),
        .line_disconnector_open_in(p[1]), .vt_small_breaker_open_in(p[0]),
        .voltage_block_out(vb), .three_phase_fail_out(tp));
    task automatic go(input logic [18:0] v, input int n);
        #1 st = v;
        repeat (n) @(posedge clk_in);
    endtask
    task automatic chk(input logic ev, input logic et);
        #2;
        samples_checked++;
        if (vb !== ev || tp !== et) begin
            num_errors++;
            $display("[FAIL] %0t outputs %b %b", $time, vb, tp);
        end
    endtask
    task automatic results;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic t_neg_seq;
        go(19'h40000, 6); chk(0, 0);
        go(19'h60000, 3); chk(1, 0);
        go(19'h0, 6); chk(0, 0);
        go(19'h7c010, 3); chk(1, 0);
        go(19'h7c010, 40); chk(1, 1);
        go(19'h1c010, 10); chk(1, 1);
        go(19'h0, 6); chk(0, 0);
        $display("neg seq test done");
    endtask
    task automatic t_delta;
        go(19'h04900, 1);
        go(19'h04800, 4); chk(1, 0);
        go(19'h1f810, 40); chk(1, 1);
        go(19'h0, 6); chk(0, 0);
        go(19'h00800, 3);
        go(19'h00900, 4); chk(0, 0);
        go(19'h0, 3);
        $display("delta test done");
    endtask
    task automatic t_contacts;
        go(19'h1, 6); chk(1, 0);
        go(19'h2, 6); chk(1, 0);
        go(19'h6000b, 6); chk(0, 0);
        go(19'h0, 6); chk(0, 0);
        $display("contact test done");
    endtask
    task automatic t_long;
        go(19'h1c000, 3);
        go(19'h400e4, 40); chk(0, 0);
        go(19'h400e4, 60); chk(1, 0);
        go(19'h0, 6); chk(0, 0);
        $display("long qualification test done");
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            results;
        end
    end
    initial begin
        repeat (20) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        repeat (4) @(posedge clk_in);
        t_neg_seq;
        t_delta;
        t_contacts;
        t_long;
        results;
    end
endmodule // ffs_fuse_fail_supervisor_tb
